// ---- spi_guard.sv ----
// Serial slave with pause pin handling and low-supply write guard
`timescale 1ns/1ps
module spi_guard
  import spi_guard_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input  wire logic i_ref_clk,    // 100 MHz system clock
  input  wire logic i_rst_n,      // Power-on reset, active low
  input  wire logic i_ce,         // Clock enable for system domain
  input  wire logic i_sck,        // Serial clock from host
  input  wire logic i_cs_n,       // Chip select, active low
  input  wire logic i_si,         // Serial data in
  input  wire logic i_hold_n,     // Pause pin, active low
  input  wire logic i_low_supply, // Low-supply detector, high = low
  output logic      o_so,         // Serial data out
  output logic      o_so_oe_n,    // Output enable, low = drive
  output logic      o_paused,     // Pause state
  output logic      o_write_busy, // Internal write in progress
  output logic      o_write_enable_latch // Write enable latch
);

  // ---------------------------------------------------------------
  // Link domain: shift in on rising edges
  // ---------------------------------------------------------------
  logic        link_rst_n;
  logic [5:0]  bits;
  logic [5:0]  next_bits;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [23:0] addr_sh;
  logic [23:0] next_addr_sh;
  logic [7:0]  opcode;
  logic [7:0]  next_opcode;
  frame_sum_t  sum;
  frame_sum_t  next_sum;

  // Deselection ends the frame asynchronously, even mid-pause
  assign link_rst_n = i_rst_n & ~i_cs_n; // R3

  always_comb begin
    next_bits    = bits;
    next_shift   = shift;
    next_addr_sh = addr_sh;
    next_opcode  = opcode;
    // Pause pin is host-driven on this clock; freeze everything
    if (i_hold_n) begin // R1 R13
      next_bits  = (bits == CNT_WRITE_WRAP) ? CNT_WRAP_TO : 6'(bits + 6'h01);
      next_shift = {shift[6:0], i_si};
      if (bits == CNT_OPCODE_LAST) begin
        next_opcode = {shift[6:0], i_si};
      end
      if (bits >= CNT_OPCODE_DONE && bits <= CNT_ADDR_LAST) begin
        next_addr_sh = {addr_sh[22:0], i_si};
      end
    end
    next_sum = '{opcode: next_opcode, bits: next_bits, addr: next_addr_sh[16:0]};
  end

  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bits    <= '0;
      shift   <= '0;
      addr_sh <= '0;
      opcode  <= '0;
    end else begin
      bits    <= next_bits;
      shift   <= next_shift;
      addr_sh <= next_addr_sh;
      opcode  <= next_opcode;
    end
  end

  // Summary survives deselection so the system side can read it
  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum <= '0;
    end else begin
      sum <= next_sum;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: status read shifts out on falling edges
  // ---------------------------------------------------------------
  logic          sck_n;
  logic [3:0]    st_link;
  logic          so_bit;
  logic          next_so_bit;
  logic          rd_live;
  logic          next_rd_live;
  guard_status_t st_pub;
  logic [7:0]    st_byte;

  assign sck_n   = ~i_sck;
  assign st_byte = {4'h0, st_link};

  // Published status is frozen while selected unless supply is low, so bits cannot skew
  spi_guard_sync #(.W(4)) u_st_sync (
    .i_clk   (sck_n),
    .i_rst_n (i_rst_n),
    .i_ce    (1'b1),
    .i_d     (st_pub),
    .o_q     (st_link)
  );

  always_comb begin
    next_so_bit  = so_bit;
    next_rd_live = (opcode == CMD_STATUS_READ) && (bits >= CNT_OPCODE_DONE);
    // Falling edge with pause low: pause takes effect here
    if (i_hold_n && next_rd_live) begin // R6 R7
      next_so_bit = st_byte[3'h7 - bits[2:0]];
    end
  end

  always_ff @(posedge sck_n or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_bit  <= 1'b0;
      rd_live <= 1'b0;
    end else begin
      so_bit  <= next_so_bit;
      rd_live <= next_rd_live;
    end
  end

  // ---------------------------------------------------------------
  // System domain: pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pins_s;
  logic       cs_s;
  logic       sck_s;
  logic       hold_s;
  logic       low_s;
  logic       so_s;
  logic       rd_s;
  logic       nsel_s;
  logic       sel_s;
  logic       hold_on_s;

  // Active-low pins enter inverted so a reset synchroniser reads as idle
  spi_guard_sync #(.W(7)) u_pin_sync (
    .i_clk   (i_ref_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     ({~i_cs_n, i_sck, ~i_hold_n, i_low_supply, so_bit, rd_live, ~i_cs_n}),
    .o_q     (pins_s)
  );

  assign {sel_s, sck_s, hold_on_s, low_s, so_s, rd_s, nsel_s} = pins_s;
  assign cs_s   = ~sel_s;
  assign hold_s = ~hold_on_s;

  // ---------------------------------------------------------------
  // System domain: pause state and output pin
  // ---------------------------------------------------------------
  logic cs_q;
  logic next_cs_q;
  logic next_paused;
  logic next_so;
  logic next_so_oe_n;

  always_comb begin
    next_cs_q   = cs_s;
    next_paused = o_paused;
    if (cs_s) begin
      next_paused = 1'b0; // R3
    end else if (!sck_s) begin
      next_paused = ~hold_s; // R4 R5
    end
    next_so      = so_s;
    // Drive only for a live read, selected and not paused
    next_so_oe_n = ~(rd_s && nsel_s && !cs_s && !next_paused); // R1 R14
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_q      <= 1'b1;
      o_paused  <= 1'b0;
      o_so      <= 1'b0;
      o_so_oe_n <= 1'b1;
    end else if (i_ce) begin
      cs_q      <= next_cs_q;
      o_paused  <= next_paused;
      o_so      <= next_so;
      o_so_oe_n <= next_so_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // System domain: write guard
  // ---------------------------------------------------------------
  wr_state_t     wr_state;
  wr_state_t     next_wr_state;
  logic [31:0]   wr_timer;
  logic [31:0]   next_wr_timer;
  logic          next_wel;
  logic [1:0]    bp;
  logic [1:0]    next_bp;
  logic [1:0]    bp_pend;
  logic [1:0]    next_bp_pend;
  guard_status_t next_st_pub;
  logic          frame_end;
  logic          wr_ok;

  // Frame summary is stable once select has risen: the clock is parked
  assign frame_end = cs_s & ~cs_q; // R10
  assign wr_ok     = o_write_enable_latch && (wr_state == WR_IDLE); // R12

  always_comb begin
    next_wr_state = wr_state;
    next_wr_timer = wr_timer;
    next_wel      = o_write_enable_latch;
    next_bp       = bp;
    next_bp_pend  = bp_pend;
    if (wr_state != WR_IDLE) begin
      if (wr_timer == 32'h0) begin
        next_wr_state = WR_IDLE;
        next_wel      = 1'b0;
        if (wr_state == WR_STATUS) begin
          next_bp = bp_pend;
        end
      end else begin
        next_wr_timer = 32'(wr_timer - 32'h1);
      end
    end
    // Writes may only start on deselection
    if (frame_end) begin // R10
      case (sum.opcode)
        CMD_WRITE_ENABLE: begin
          if (wr_state == WR_IDLE) begin
            next_wel = 1'b1;
          end
        end
        CMD_WRITE_DISABLE: begin
          if (wr_state == WR_IDLE) begin
            next_wel = 1'b0;
          end
        end
        CMD_STATUS_WRITE: begin
          if (wr_ok && sum.bits == CNT_STATUS_WR) begin // R12
            next_wr_state = WR_STATUS;
            next_wr_timer = 32'(WRITE_CYCLES_P - 1);
            next_bp_pend  = sum.addr[ST_BP_LSB+1:ST_BP_LSB];
          end
        end
        CMD_MEM_WRITE: begin
          if (wr_ok && sum.bits == CNT_WRITE_WRAP && !is_protected(bp, sum.addr)) begin // R12
            next_wr_state = WR_MEM;
            next_wr_timer = 32'(WRITE_CYCLES_P - 1);
          end
        end
        default: begin
        end
      endcase
    end
    // Low supply overrides state, timer and latch, including a latch set
    if (low_s) begin // R8
      next_wr_state = WR_IDLE;
      next_wr_timer = 32'h0;
      next_wel      = 1'b0;
    end
    next_st_pub = st_pub;
    if (cs_s || low_s) begin
      next_st_pub = '{bp: next_bp, write_enable_latch: next_wel, busy: (next_wr_state != WR_IDLE)};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_state             <= WR_IDLE; // R8
      wr_timer             <= 32'h0;
      o_write_enable_latch <= 1'b0;
      o_write_busy         <= 1'b0;
      bp                   <= BP_RESET;
      bp_pend              <= BP_RESET;
      st_pub               <= '0;
    end else if (i_ce) begin
      wr_state             <= next_wr_state;
      wr_timer             <= next_wr_timer;
      o_write_enable_latch <= next_wel;
      o_write_busy         <= (next_wr_state != WR_IDLE);
      bp                   <= next_bp;
      bp_pend              <= next_bp_pend;
      st_pub               <= next_st_pub;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_low_seen;
    i_ce && low_s;
  endsequence

  sequence s_guard_clear;
    !o_write_enable_latch && !o_write_busy;
  endsequence

  a_low_supply_abort: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R8
    s_low_seen |=> s_guard_clear)
    else $error("low supply did not abort write");

  a_paused_floats: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R1
    o_paused |-> o_so_oe_n)
    else $error("output driven while paused");

  a_desel_unpause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R3
    i_ce && cs_s |=> !o_paused)
    else $error("pause held while deselected");

  a_pause_clk_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R4
    i_ce && !cs_s && !sck_s && !hold_s |=> o_paused)
    else $error("pause not taken with clock low");

  a_release_clk_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R5
    i_ce && !cs_s && !sck_s && hold_s |=> !o_paused)
    else $error("pause not released with clock low");

  a_pause_clk_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R6
    i_ce && !cs_s && sck_s |=> o_paused == $past(o_paused))
    else $error("pause changed with clock high");

  a_write_start_desel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
    i_ce && $rose(o_write_busy) |-> cs_s && !$past(cs_q))
    else $error("write started while not deselecting");

  a_write_refused: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    i_ce && frame_end && !wr_ok |=> !$rose(o_write_busy))
    else $error("write accepted without latch or while busy");

  a_read_only_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R14
    !o_so_oe_n |-> $past(rd_s) && !$past(cs_s))
    else $error("output driven without live read");

  a_busy_ends_wel: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R8
    i_ce && $fell(o_write_busy) |-> !o_write_enable_latch)
    else $error("latch set after write end");

endmodule

// ---- spi_guard_pkg.sv ----
// Constants and carrier types for the pause and supply-guard serial slave
// Operation
// [R1] Paused: output floats, input and clock ignored
// [R2] Host keeps select low while pausing
// [R3] Select raised while paused ends transaction
// [R4] Pause edge with clock low starts pause
// [R5] Release edge with clock low ends pause
// [R6] Pause with clock high waits falling edge
// [R7] Release with clock high waits falling edge
// [R8] Low supply aborts writes, clears enable latch
// [R9] Host re-enables writes after supply recovery
// [R10] No write starts while selected
// [R11] Host holds select high at power events
// [R12] Write refused: no latch, busy, protected
// [R13] Pause freezes counter, shifter and address
// [R14] Output resumes only for live read
package spi_guard_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
  localparam logic [7:0] CMD_MEM_WRITE     = 8'h02;

  // ---------------------------------------------------------------
  // Frame bit counts
  // ---------------------------------------------------------------
  localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
  localparam logic [5:0] CNT_OPCODE_DONE = 6'h08;
  localparam logic [5:0] CNT_ADDR_LAST   = 6'h1F;
  localparam logic [5:0] CNT_STATUS_WR   = 6'h10;
  localparam logic [5:0] CNT_WRITE_WRAP  = 6'h28;
  localparam logic [5:0] CNT_WRAP_TO     = 6'h21;

  // ---------------------------------------------------------------
  // Protection boundaries and status layout
  // ---------------------------------------------------------------
  localparam logic [16:0] PROT_QUARTER = 17'h18000;
  localparam logic [16:0] PROT_HALF    = 17'h10000;
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_WEL_BIT   = 1;
  localparam int          ST_BP_LSB    = 2;
  localparam logic [1:0]  BP_RESET     = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [5:0]  bits;
    logic [16:0] addr;
  } frame_sum_t;

  typedef struct packed {
    logic [1:0] bp;
    logic       write_enable_latch;
    logic       busy;
  } guard_status_t;

  typedef enum logic [1:0] {WR_IDLE, WR_MEM, WR_STATUS} wr_state_t;

  function automatic logic is_protected(input logic [1:0] bp, input logic [16:0] addr);
    case (bp)
      2'h1:    is_protected = (addr >= PROT_QUARTER);
      2'h2:    is_protected = (addr >= PROT_HALF);
      2'h3:    is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction

endpackage

// ---- spi_guard_sync.sv ----
// Two-flop level synchroniser, one bus of independent levels
`timescale 1ns/1ps
module spi_guard_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Destination clock
  input  wire logic         i_rst_n, // Async reset, active low
  input  wire logic         i_ce,    // Clock enable
  input  wire logic [W-1:0] i_d,     // Asynchronous levels
  output logic      [W-1:0] o_q      // Synchronised levels
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = i_ce ? i_d  : meta;
    next_q    = i_ce ? meta : o_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end
endmodule

// ---- spi_host_model.sv ----
// Host controller model driving the serial bus and the pause pin
`timescale 1ns/1ps
module spi_host_model #(
  parameter realtime HALF_NS = 40.0
) (
  input  wire logic i_so,      // Serial data from slave
  input  wire logic i_so_oe_n, // Slave output enable, low = drive
  output logic      o_sck,     // Serial clock, stands low between frames
  output logic      o_cs_n,    // Chip select, active low
  output logic      o_si,      // Serial data to slave
  output logic      o_hold_n   // Pause pin, active low
);
  logic [7:0] rx;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    rx = 8'h00;
  end

  // ---------------------------------------------------------------
  // Bus primitives
  // ---------------------------------------------------------------
  // Odd skew keeps link edges off the system clock grid
  task automatic select(input logic v);
    #(HALF_NS + 3.3) o_cs_n = !v;
    if (!v) begin
      o_si = !o_si;
    end
  endtask

  task automatic edge_up();
    #(HALF_NS) o_sck = 1'b1;
    rx = {rx[6:0], i_so_oe_n ? 1'bz : i_so};
  endtask

  task automatic edge_down();
    #(HALF_NS) o_sck = 1'b0;
  endtask

  task automatic shift(input logic [63:0] d, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      o_si = d[k];
      edge_up();
      edge_down();
    end
  endtask

  // Clock and data wiggle that a paused slave must ignore
  task automatic noise(input int n);
    repeat (n) begin
      o_si = !o_si;
      edge_up();
      edge_down();
    end
  endtask

  // Select is never touched here, so it stays low across a pause
  task automatic pause(input logic v);
    #(HALF_NS) o_hold_n = !v;
  endtask

  task automatic frame(input logic [63:0] d, input int n);
    select(1'b1);
    shift(d, n);
    select(1'b0);
  endtask
endmodule

// ---- test_spi_guard.sv ----
// Self-checking bench for the pause and supply-guard serial slave
`timescale 1ns/1ps
`define CHECK(act, exp) check(act, exp)
module test_spi_guard
  import spi_guard_pkg::*;
;
  localparam int WCYC = 150;
  logic i_ref_clk;
  logic ce;
  logic i_rst_n;
  logic i_low_supply;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic o_so;
  logic o_so_oe_n;
  logic o_paused;
  logic o_write_busy;
  logic o_write_enable_latch;
  int   error_cnt;
  int   n_checks;

  spi_guard #(.WRITE_CYCLES_P(WCYC)) i_spi_guard (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_low_supply(i_low_supply), .o_so(o_so),
    .o_so_oe_n(o_so_oe_n), .o_paused(o_paused), .o_write_busy(o_write_busy),
    .o_write_enable_latch(o_write_enable_latch)
  );

  spi_host_model i_spi_host_model (
    .i_so(o_so), .i_so_oe_n(o_so_oe_n), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n)
  );

  always #5 i_ref_clk = ~i_ref_clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_ref(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (o_write_busy !== 1'b0 && k < 200) begin
      wait_ref(1);
      k++;
    end
    if (k >= 200) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // Write enable first, as the host must after any supply event
  task automatic enable();
    i_spi_host_model.frame(CMD_WRITE_ENABLE, 8);
    wait_ref(6);
  endtask

  task automatic mem_write();
    i_spi_host_model.frame({CMD_MEM_WRITE, 24'h000100, 8'hA5}, 40);
    wait_ref(6);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    `CHECK(o_so_oe_n, 1'b1);
    `CHECK({o_paused, o_write_busy, o_write_enable_latch}, 3'h0);
    $display("t_reset done");
  endtask

  task automatic t_writes();
    mem_write();
    `CHECK(o_write_busy, 1'b0);
    enable();
    `CHECK(o_write_enable_latch, 1'b1);
    i_spi_host_model.frame({CMD_STATUS_READ, 8'h00}, 16);
    `CHECK(i_spi_host_model.rx, 8'h02);
    i_spi_host_model.frame({CMD_STATUS_WRITE, 7'h03}, 15);
    wait_ref(6);
    `CHECK(o_write_busy, 1'b0);
    i_spi_host_model.frame({CMD_STATUS_WRITE, 8'h0C}, 16);
    wait_ref(6);
    `CHECK(o_write_busy, 1'b1);
    wait_idle();
    `CHECK(o_write_enable_latch, 1'b0);
    enable();
    mem_write();
    `CHECK(o_write_busy, 1'b0);
    i_spi_host_model.frame({CMD_STATUS_WRITE, 8'h00}, 16);
    wait_ref(6);
    wait_idle();
    enable();
    mem_write();
    `CHECK(o_write_busy, 1'b1);
    // Busy outlasts this frame, so the enable is ignored
    enable();
    `CHECK(o_write_enable_latch, 1'b1);
    wait_idle();
    `CHECK(o_write_enable_latch, 1'b0);
    $display("t_writes done");
  endtask

  task automatic t_pause_low();
    i_spi_host_model.select(1'b1);
    i_spi_host_model.shift(CMD_STATUS_READ, 8);
    i_spi_host_model.shift(2'h0, 2);
    i_spi_host_model.pause(1'b1);
    wait_ref(4);
    `CHECK({o_paused, o_so_oe_n}, 2'h3);
    i_spi_host_model.noise(3);
    `CHECK({o_paused, o_so_oe_n}, 2'h3);
    i_spi_host_model.pause(1'b0);
    wait_ref(4);
    `CHECK({o_paused, o_so_oe_n}, 2'h0);
    i_spi_host_model.select(1'b0);
    wait_ref(6);
    `CHECK(o_so_oe_n, 1'b1);
    $display("t_pause_low done");
  endtask

  task automatic t_pause_freeze();
    i_spi_host_model.select(1'b1);
    i_spi_host_model.shift(4'h0, 4);
    i_spi_host_model.pause(1'b1);
    i_spi_host_model.noise(5);
    i_spi_host_model.pause(1'b0);
    wait_ref(6);
    `CHECK(o_so_oe_n, 1'b1);
    i_spi_host_model.shift(4'h6, 4);
    i_spi_host_model.select(1'b0);
    wait_ref(6);
    `CHECK(o_write_enable_latch, 1'b1);
    $display("t_pause_freeze done");
  endtask

  task automatic t_pause_high();
    i_spi_host_model.select(1'b1);
    i_spi_host_model.shift(CMD_STATUS_READ, 8);
    i_spi_host_model.edge_up();
    i_spi_host_model.pause(1'b1);
    wait_ref(6);
    `CHECK(o_paused, 1'b0);
    i_spi_host_model.edge_down();
    wait_ref(6);
    `CHECK(o_paused, 1'b1);
    i_spi_host_model.edge_up();
    i_spi_host_model.pause(1'b0);
    wait_ref(6);
    `CHECK(o_paused, 1'b1);
    i_spi_host_model.edge_down();
    wait_ref(6);
    `CHECK(o_paused, 1'b0);
    i_spi_host_model.pause(1'b1);
    wait_ref(6);
    i_spi_host_model.select(1'b0);
    wait_ref(6);
    `CHECK({o_paused, o_so_oe_n}, 2'h1);
    i_spi_host_model.pause(1'b0);
    $display("t_pause_high done");
  endtask

  // Clock enable low freezes the pause state until it returns
  task automatic t_clock_enable();
    i_spi_host_model.select(1'b1);
    wait_ref(6);
    ce = 1'b0;
    i_spi_host_model.pause(1'b1);
    wait_ref(6);
    `CHECK(o_paused, 1'b0);
    ce = 1'b1;
    wait_ref(4);
    `CHECK({o_paused, o_so_oe_n}, 2'h3);
    i_spi_host_model.pause(1'b0);
    wait_ref(4);
    `CHECK(o_paused, 1'b0);
    i_spi_host_model.select(1'b0);
    wait_ref(6);
    $display("t_clock_enable done");
  endtask

  task automatic t_supply();
    mem_write();
    `CHECK(o_write_busy, 1'b1);
    i_low_supply = 1'b1;
    wait_ref(5);
    `CHECK({o_write_busy, o_write_enable_latch}, 2'h0);
    i_low_supply = 1'b0;
    wait_ref(4);
    mem_write();
    `CHECK(o_write_busy, 1'b0);
    i_spi_host_model.shift(CMD_WRITE_ENABLE, 8);
    wait_ref(6);
    `CHECK(o_write_enable_latch, 1'b0);
    $display("t_supply done");
  endtask

  initial begin
    i_ref_clk = 1'b0;
    i_rst_n = 1'b0;
    i_low_supply = 1'b0;
    ce = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    wait_ref(4);
    t_reset();
    t_writes();
    t_pause_low();
    t_pause_freeze();
    t_pause_high();
    t_clock_enable();
    t_supply();
    report_and_stop();
  end
endmodule
